// [src/usbifr_pkg.sv]
// Purpose: Constants for the USB interface unit status register slice.
// Assumes: 32-bit AXI4-Lite register access, byte addresses as listed.
// Notes: Offsets, field positions and the line control reset value live here only.
package usbifr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // Register byte offsets.
    localparam logic [7:0] OFS_OTG_CTRL = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h1c;
    localparam logic [7:0] OFS_STICKY = 8'h20;
    localparam logic [7:0] OFS_PID = 8'h2c;
    localparam logic [7:0] OFS_ENDP = 8'h30;
    localparam logic [7:0] OFS_EP_MARK = 8'h34;
    localparam logic [7:0] OFS_OTG_MASK = 8'h38;
    localparam logic [7:0] OFS_POWER = 8'h3c;
    localparam logic [7:0] OFS_DEV_ADDR = 8'h08;
    // Line control fields.
    localparam int unsigned OTG_RXRCV = 6;
    localparam int unsigned OTG_RXDM = 5;
    localparam int unsigned OTG_RXDP = 4;
    localparam int unsigned OTG_TXSE0 = 3;
    localparam int unsigned OTG_TXDATA = 2;
    localparam int unsigned OTG_TXEN_N = 1;
    localparam int unsigned OTG_FSLS = 0;
    localparam logic [3:0] OTG_CTRL_RST = 4'h2;
    // Flag fields.
    localparam int unsigned FLAG_W = 7;
    localparam int unsigned FLG_TOKEN = 6;
    localparam int unsigned FLG_SE0 = 5;
    localparam int unsigned FLG_K = 4;
    localparam int unsigned FLG_J = 3;
    localparam int unsigned FLG_CRC16 = 2;
    localparam int unsigned FLG_RXACT = 1;
    localparam int unsigned FLG_RXERR = 0;
    // Linestate encodings.
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    // Widths and masks.
    localparam int unsigned PID_W = 4;
    localparam int unsigned EP_W = 4;
    localparam int unsigned EP_N = 16;
    localparam int unsigned DEVADDR_W = 7;
    localparam int unsigned POWER_W = 9;
    localparam logic [4:0] EP_MARK_OR = 5'h10;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : usbifr_pkg

// [src/usbifr_regs.sv]
// Purpose: OTG line control, signal flags, PID/endpoint capture registers.
// Assumes: Transceiver and packet-side inputs are synchronous to aclk.
// Notes: AXI4-Lite slave, one write and one read in flight at most.
`timescale 1ns/1ps
module usbifr_regs (
    input wire logic aclk, // System clock, 10 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [usbifr_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [usbifr_pkg::DATA_W-1:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [usbifr_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [usbifr_pkg::DATA_W-1:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic utmi_rxrcv, // Differential receive level.
    input wire logic utmi_rxdm, // D- receive level.
    input wire logic utmi_rxdp, // D+ receive level.
    input wire logic [1:0] utmi_linestate, // Line state.
    input wire logic utmi_rxactive, // Receive active.
    input wire logic utmi_rxerror, // Receive error.
    output logic utmi_txse0, // Single-ended-zero transmit.
    output logic utmi_txdata, // Serial transmit data.
    output logic utmi_txenable_n, // Transmit enable, active low.
    output logic utmi_fslsserial, // Full/low-speed serial mode.
    input wire logic pkt_start, // Pulse: a new packet begins.
    input wire logic tok_valid, // Pulse: token decoded, CRC5/PID fine.
    input wire logic [6:0] tok_addr, // Address carried by the token.
    input wire logic [3:0] tok_pid, // PID of the token.
    input wire logic [3:0] tok_ep, // Endpoint of the token.
    input wire logic pid_valid, // Pulse: a packet PID was received.
    input wire logic [3:0] pid_value, // PID of that packet.
    input wire logic crc16_fail, // Pulse: data packet failed CRC16.
    output logic rx_ep_valid, // Endpoint on receive port is valid.
    output logic [4:0] rx_ep // Endpoint toward receive port.
);
    import usbifr_pkg::*;

    // Every check below runs on aclk and is quiet while reset is held.
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Only four bytes per register, so byte-aligned word addressing is used.
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : strb_merge

    function automatic logic addr_known(input logic [7:0] a);
        return (a == OFS_OTG_CTRL) || (a == OFS_FLAGS) ||
            (a == OFS_STICKY) || (a == OFS_PID) || (a == OFS_ENDP) ||
            (a == OFS_EP_MARK) || (a == OFS_OTG_MASK) ||
            (a == OFS_POWER) || (a == OFS_DEV_ADDR);
    endfunction : addr_known

    logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff, araddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [3:0] otg_ctrl_ff;
    logic [FLAG_W-1:0] flags_ff, sticky_ff;
    logic [PID_W-1:0] pid_ff;
    logic [EP_W-1:0] ep_ff;
    logic ep_valid_ff;
    logic [EP_N-1:0] ep_mark_ff;
    logic [31:0] otg_mask_ff;
    logic [POWER_W-1:0] power_ff;
    logic [DEVADDR_W-1:0] dev_addr_ff;
    logic [4:0] rx_ep_ff;
    logic rx_ep_valid_ff;

    // Write channel: address and data are captured independently.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [7:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
    wire have_aw = aw_held_ff || aw_take;
    wire have_w = w_held_ff || w_take;
    wire wr_fire = have_aw && have_w && !bvalid_ff;
    wire wr_hit = wr_fire && addr_known(wr_addr);
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    wire wr_otg = wr_hit && (wr_addr == OFS_OTG_CTRL);
    wire wr_flags = wr_hit && (wr_addr == OFS_FLAGS);
    wire wr_sticky = wr_hit && (wr_addr == OFS_STICKY);
    wire wr_mark = wr_hit && (wr_addr == OFS_EP_MARK);
    wire wr_mask = wr_hit && (wr_addr == OFS_OTG_MASK);
    wire wr_power = wr_hit && (wr_addr == OFS_POWER);
    wire wr_dev = wr_hit && (wr_addr == OFS_DEV_ADDR);
    wire [31:0] otg_m = strb_merge({28'h0, otg_ctrl_ff}, wr_data, wr_strb);
    wire [31:0] wr_bits = strb_merge(32'h0, wr_data, wr_strb);
    // Unstrobed bytes keep their contents, so every register merges.
    // A zero fill here would silently clear the power valid bit on a
    // byte-wide write of the data field.
    wire [31:0] sticky_m = strb_merge(32'(sticky_ff), wr_data, wr_strb);
    wire [31:0] mark_m = strb_merge(32'(ep_mark_ff), wr_data, wr_strb);
    wire [31:0] power_m = strb_merge(32'(power_ff), wr_data, wr_strb);
    wire [31:0] dev_m = strb_merge(32'(dev_addr_ff), wr_data, wr_strb);

    // Write handshake state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= 8'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_take) awaddr_ff <= s_axi_awaddr;
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            aw_held_ff <= have_aw && !wr_fire;
            w_held_ff <= have_w && !wr_fire;
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= addr_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Token accepted only when addressed to this device.
    wire tok_ours = tok_valid && (tok_addr == dev_addr_ff);

    // Raw events per flag; line levels follow the live signals.
    wire [FLAG_W-1:0] flag_evt = {tok_ours,
                                  utmi_linestate == LS_SE0,
                                  utmi_linestate == LS_K,
                                  utmi_linestate == LS_J,
                                  crc16_fail,
                                  utmi_rxactive,
                                  utmi_rxerror};
    // Level-tracking flags: line states and receive signals overwrite.
    // Token and CRC flags are events, so only they wait for a packet.
    localparam logic [FLAG_W-1:0] EVENT_MASK =
        FLAG_W'((1 << FLG_TOKEN) | (1 << FLG_CRC16));
    localparam logic [FLAG_W-1:0] LEVEL_MASK = ~EVENT_MASK;
    // Sticky: set wins over a software clear arriving together.
    wire [FLAG_W-1:0] clr = wr_flags ? wr_bits[FLAG_W-1:0] : '0;
    wire [FLAG_W-1:0] sticky_nxt = (flags_ff & ~clr) | flag_evt;
    // Non-sticky: level bits track, event bits hold until next packet.
    wire [FLAG_W-1:0] pkt_keep = pkt_start ? '0 : flags_ff;
    wire [FLAG_W-1:0] plain_nxt = (LEVEL_MASK & flag_evt) |
        (~LEVEL_MASK & (pkt_keep | flag_evt));
    wire [FLAG_W-1:0] nxt_flags = (sticky_ff & sticky_nxt) |
        (~sticky_ff & plain_nxt);

    // Software-writable control and storage registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            otg_ctrl_ff <= OTG_CTRL_RST;
            sticky_ff <= '0;
            ep_mark_ff <= '0;
            otg_mask_ff <= 32'h0;
            power_ff <= '0;
            dev_addr_ff <= '0;
        end else begin
            if (wr_otg) otg_ctrl_ff <= otg_m[3:0];
            if (wr_sticky) sticky_ff <= sticky_m[FLAG_W-1:0];
            if (wr_mark) ep_mark_ff <= mark_m[EP_N-1:0];
            if (wr_mask) otg_mask_ff <= strb_merge(otg_mask_ff, wr_data,
                                                   wr_strb);
            if (wr_power) power_ff <= power_m[POWER_W-1:0];
            if (wr_dev) dev_addr_ff <= dev_m[DEVADDR_W-1:0];
        end
    end

    // Flag and capture state driven by the packet side.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= '0;
            pid_ff <= '0;
            ep_ff <= '0;
            ep_valid_ff <= 1'b0;
            rx_ep_ff <= 5'h0;
            rx_ep_valid_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            if (pid_valid) pid_ff <= pid_value;
            else if (tok_ours) pid_ff <= tok_pid;
            if (tok_ours) begin
                ep_ff <= tok_ep;
                ep_valid_ff <= 1'b1;
                rx_ep_ff <= ep_mark_ff[tok_ep] ?
                    ({1'b0, tok_ep} | EP_MARK_OR) : {1'b0, tok_ep};
            end
            rx_ep_valid_ff <= tok_ours;
        end
    end

    // Transceiver drive comes straight from the control bits.
    assign utmi_txse0 = otg_ctrl_ff[OTG_TXSE0];
    assign utmi_txdata = otg_ctrl_ff[OTG_TXDATA];
    assign utmi_txenable_n = otg_ctrl_ff[OTG_TXEN_N];
    assign utmi_fslsserial = otg_ctrl_ff[OTG_FSLS];
    assign rx_ep = rx_ep_ff;
    assign rx_ep_valid = rx_ep_valid_ff;

    // Read mux; unknown addresses return zero with SLVERR.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (araddr_ff)
            OFS_OTG_CTRL: begin
                rd_mux[OTG_RXRCV] = utmi_rxrcv;
                rd_mux[OTG_RXDM] = utmi_rxdm;
                rd_mux[OTG_RXDP] = utmi_rxdp;
                rd_mux[3:0] = otg_ctrl_ff;
            end
            OFS_FLAGS: rd_mux[FLAG_W-1:0] = flags_ff;
            OFS_STICKY: rd_mux[FLAG_W-1:0] = sticky_ff;
            OFS_PID: rd_mux[PID_W-1:0] = pid_ff;
            OFS_ENDP: rd_mux[EP_W:0] = {ep_valid_ff, ep_ff};
            OFS_EP_MARK: rd_mux[EP_N-1:0] = ep_mark_ff;
            OFS_OTG_MASK: rd_mux = otg_mask_ff;
            OFS_POWER: rd_mux[POWER_W-1:0] = power_ff;
            OFS_DEV_ADDR: rd_mux[DEVADDR_W-1:0] = dev_addr_ff;
            default: rd_mux = 32'h0;
        endcase
    end

    // Read channel: address taken, data answered two cycles after the handshake.
    logic ar_pend_ff;
    assign s_axi_arready = !ar_pend_ff && !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_pend_ff <= 1'b0;
            araddr_ff <= 8'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                araddr_ff <= s_axi_araddr;
                ar_pend_ff <= 1'b1;
            end else if (ar_pend_ff) begin
                ar_pend_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= addr_known(araddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Line control: reset values and software writes reach the pins, and the D+ level reads back.
    a_txen_reset: assert property ($rose(aresetn) |->
        utmi_txenable_n && !utmi_txse0 && !utmi_txdata && !utmi_fslsserial)
        else $error("transmit lines wrong after reset");
    a_otg_write: assert property (wr_otg && wr_strb[0] |=>
        utmi_txse0 == $past(wr_data[OTG_TXSE0]))
        else $error("txse0 not written");
    a_txdata_write: assert property (wr_otg && wr_strb[0] |=>
        utmi_txdata == $past(wr_data[OTG_TXDATA]))
        else $error("txdata not written");
    a_txen_write: assert property (wr_otg && wr_strb[0] |=>
        utmi_txenable_n == $past(wr_data[OTG_TXEN_N]))
        else $error("transmit enable not written");
    a_fsls_write: assert property (wr_otg && wr_strb[0] |=>
        utmi_fslsserial == $past(wr_data[OTG_FSLS]))
        else $error("fsls mode not written");
    a_line_read: assert property (ar_pend_ff &&
        araddr_ff == OFS_OTG_CTRL |=>
        s_axi_rdata[OTG_RXDP] == $past(utmi_rxdp))
        else $error("D+ level not read back");

    // Flags: sticky hold and clear, events, and live level tracking.
    a_sticky_hold: assert property (sticky_ff[FLG_CRC16] &&
        flags_ff[FLG_CRC16] && !wr_flags |=> flags_ff[FLG_CRC16])
        else $error("sticky flag lost");
    a_sticky_clear: assert property (wr_flags && !crc16_fail &&
        sticky_ff[FLG_CRC16] && wr_bits[FLG_CRC16] |=>
        !flags_ff[FLG_CRC16])
        else $error("sticky flag not cleared");
    a_crc_flag: assert property (crc16_fail |=> flags_ff[FLG_CRC16])
        else $error("crc16 flag not set");
    a_token_flag: assert property (tok_ours |=> flags_ff[FLG_TOKEN])
        else $error("token flag not set");
    a_se0_follow: assert property (!sticky_ff[FLG_SE0] |=>
        flags_ff[FLG_SE0] == ($past(utmi_linestate) == LS_SE0))
        else $error("SE0 flag wrong");
    a_rxact_follow: assert property (!sticky_ff[FLG_RXACT] |=>
        flags_ff[FLG_RXACT] == $past(utmi_rxactive))
        else $error("rxactive flag wrong");
    a_pkt_clear: assert property (pkt_start && !crc16_fail &&
        !sticky_ff[FLG_CRC16] |=> !flags_ff[FLG_CRC16])
        else $error("flag not cleared on packet");

    // Packet capture and the receive port.
    a_pid_capture: assert property (pid_valid |=>
        pid_ff == $past(pid_value))
        else $error("PID not captured");
    a_token_addr: assert property (tok_valid &&
        tok_addr != dev_addr_ff |=> !rx_ep_valid)
        else $error("foreign token passed");
    a_ep_capture: assert property (tok_ours |=>
        ep_valid_ff && ep_ff == $past(tok_ep))
        else $error("endpoint not captured");
    a_ep_mark: assert property (tok_ours && ep_mark_ff[tok_ep] |=>
        rx_ep[EP_W])
        else $error("marked endpoint not flagged");
    a_ep_plain: assert property (tok_ours && !ep_mark_ff[tok_ep] |=>
        rx_ep == {1'b0, $past(tok_ep)})
        else $error("unmarked endpoint altered");

    // Storage registers and the bus answers.
    a_power_write: assert property (wr_power && wr_strb[1] |=>
        power_ff[POWER_W-1] == $past(wr_data[POWER_W-1]))
        else $error("power valid bit not written");
    a_mask_write: assert property (wr_mask && &wr_strb |=>
        otg_mask_ff == $past(wr_data))
        else $error("flag mask not written");
    a_dev_write: assert property (wr_dev && wr_strb[0] |=>
        dev_addr_ff == $past(wr_data[DEVADDR_W-1:0]))
        else $error("device address not written");
    a_bresp_err: assert property (wr_fire && !addr_known(wr_addr) |=>
        s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |->
        ##2 s_axi_rvalid)
        else $error("read answer late");
endmodule : usbifr_regs

// [dv/usbifr_xcvr_model.sv]
// Purpose: Transceiver stand-in that answers the line control outputs.
// Assumes: Full-speed device, so the released bus idles in J.
// Notes: The bench may override line state to reach K and SE0.
`timescale 1ns/1ps
module usbifr_xcvr_model (
    input wire logic utmi_txse0, // Single-ended-zero transmit.
    input wire logic utmi_txdata, // Serial transmit data.
    input wire logic utmi_txenable_n, // Transmit enable, active low.
    input wire logic ls_force_en, // Bench override of line state.
    input wire logic [1:0] ls_forced, // Line state while overridden.
    input wire logic act_in, // Receive activity from the bench.
    input wire logic err_in, // Receive error from the bench.
    output logic utmi_rxrcv, // Differential receive level.
    output logic utmi_rxdm, // D- level.
    output logic utmi_rxdp, // D+ level.
    output logic [1:0] utmi_linestate, // Line state.
    output logic utmi_rxactive, // Receive active.
    output logic utmi_rxerror // Receive error.
);
    logic drv;
    logic dp;
    logic dm;
    // A released bus is pulled to J; no stale driven level survives.
    assign drv = ~utmi_txenable_n;
    assign dp = drv ? (~utmi_txse0 & utmi_txdata) : 1'h1;
    assign dm = drv ? (~utmi_txse0 & ~utmi_txdata) : 1'h0;
    assign utmi_rxdp = dp;
    assign utmi_rxdm = dm;
    assign utmi_rxrcv = dp;
    assign utmi_linestate = ls_force_en ? ls_forced : {dm, dp};
    assign utmi_rxactive = act_in;
    assign utmi_rxerror = err_in;
endmodule : usbifr_xcvr_model

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the status register slice.
// Assumes: AXI4-Lite master tasks start just after a rising edge.
// Notes: Register rows first, then packet, sticky and reset cases.
`timescale 1ns/1ps
module tb_top;
    import usbifr_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w, e, r;} usbifr_row_type;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, utmi_linestate;
    logic utmi_rxrcv, utmi_rxdm, utmi_rxdp, utmi_rxactive, utmi_rxerror;
    logic utmi_txse0, utmi_txdata, utmi_txenable_n, utmi_fslsserial;
    logic ls_force_en = 1'h0, act_in = 1'h0, err_in = 1'h0;
    logic [1:0] ls_forced = 2'h0;
    logic pkt_start = 1'h0, tok_valid = 1'h0, pid_valid = 1'h0;
    logic crc16_fail = 1'h0, rx_ep_valid;
    logic [6:0] tok_addr = 7'h0;
    logic [3:0] tok_pid = 4'h0, tok_ep = 4'h0, pid_value = 4'h0;
    logic [4:0] rx_ep;
    int miscompares = 0, total_checks = 0, cycles = 0;
    // Address, written word, word read back, value read after reset.
    usbifr_row_type rows [12] = '{
        '{OFS_OTG_CTRL, 32'hd, 32'hd, 32'h52},
        '{OFS_OTG_CTRL, 32'h4, 32'h54, 32'h52},
        '{OFS_OTG_CTRL, 32'h0, 32'h20, 32'h52},
        '{OFS_OTG_CTRL, 32'hffffffff, 32'h5f, 32'h52},
        '{OFS_OTG_CTRL, 32'h2, 32'h52, 32'h52},
        '{OFS_OTG_MASK, 32'ha5a55a5a, 32'ha5a55a5a, 32'h0},
        '{OFS_POWER, 32'hffffffff, 32'h1ff, 32'h0},
        '{OFS_EP_MARK, 32'hffffffff, 32'hffff, 32'h0},
        '{OFS_PID, 32'hf, 32'h0, 32'h0},
        '{OFS_ENDP, 32'h1f, 32'h0, 32'h0},
        '{OFS_DEV_ADDR, 32'hff, 32'h7f, 32'h0},
        '{OFS_STICKY, 32'h0, 32'h0, 32'h0}};

    usbifr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .utmi_rxrcv, .utmi_rxdm,
        .utmi_rxdp, .utmi_linestate, .utmi_rxactive, .utmi_rxerror,
        .utmi_txse0, .utmi_txdata, .utmi_txenable_n, .utmi_fslsserial,
        .pkt_start, .tok_valid, .tok_addr, .tok_pid, .tok_ep, .pid_valid,
        .pid_value, .crc16_fail, .rx_ep_valid, .rx_ep);
    usbifr_xcvr_model xcvr (.utmi_txse0, .utmi_txdata, .utmi_txenable_n,
        .ls_force_en, .ls_forced, .act_in, .err_in, .utmi_rxrcv, .utmi_rxdm,
        .utmi_rxdp, .utmi_linestate, .utmi_rxactive, .utmi_rxerror);

    // Clock of 100 ns period.
    always #50 aclk = ~aclk;

    // A hung handshake ends the run well past the expected length.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic conclude();
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // Address and data are offered together and each dropped when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        // Ready stays up between writes so no step sets it twice.
        check(32'(s_axi_bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        // Ready stays up between reads so no step sets it twice.
        check(s_axi_rdata, e);
        check(32'(s_axi_rresp), 32'(er));
    endtask : rd

    // Counts receive-port strobes over three cycles after a token.
    task automatic tok(input logic [6:0] ad, input logic [3:0] ep,
            input logic [4:0] e_ep, input int e_n);
        int n;
        logic [4:0] got;
        n = 0;
        got = 5'h0;
        tok_addr <= ad;
        tok_ep <= ep;
        tok_pid <= 4'h9;
        tok_valid <= 1'h1;
        @(posedge aclk);
        tok_valid <= 1'h0;
        repeat (3) begin
            #1;
            if (rx_ep_valid === 1'h1) begin
                n++;
                got = rx_ep;
            end
            @(posedge aclk);
        end
        check(32'(n), 32'(e_n));
        check(32'(got), 32'(e_ep));
    endtask : tok

    task automatic evt(input logic [2:0] m);
        {pkt_start, crc16_fail, pid_valid} <= m;
        @(posedge aclk);
        {pkt_start, crc16_fail, pid_valid} <= 3'h0;
        @(posedge aclk);
    endtask : evt

    // Main sequence: rows, then packet side, sticky flags, errors, reset.
    initial begin
        repeat (8) @(posedge aclk);
        check(32'({utmi_txse0, utmi_txdata, utmi_txenable_n,
            utmi_fslsserial}), 32'h2);
        aresetn <= 1'h1;
        foreach (rows[i])
            rd(rows[i].a, rows[i].r, RESP_OKAY);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w, RESP_OKAY);
            rd(rows[i].a, rows[i].e, RESP_OKAY);
            if (rows[i].a == OFS_OTG_CTRL)
                check(32'({utmi_txse0, utmi_txdata, utmi_txenable_n,
                    utmi_fslsserial}), 32'(rows[i].w[3:0]));
        end
        rd(OFS_FLAGS, 32'h8, RESP_OKAY);
        ls_force_en <= 1'h1;
        ls_forced <= LS_K;
        act_in <= 1'h1;
        err_in <= 1'h1;
        @(posedge aclk);
        rd(OFS_FLAGS, 32'h13, RESP_OKAY);
        ls_forced <= LS_SE0;
        act_in <= 1'h0;
        err_in <= 1'h0;
        @(posedge aclk);
        rd(OFS_FLAGS, 32'h20, RESP_OKAY);
        ls_force_en <= 1'h0;
        tok(7'h7f, 4'h5, 5'h15, 1);
        rd(OFS_FLAGS, 32'h48, RESP_OKAY);
        rd(OFS_ENDP, 32'h15, RESP_OKAY);
        rd(OFS_PID, 32'h9, RESP_OKAY);
        evt(3'h4);
        rd(OFS_FLAGS, 32'h8, RESP_OKAY);
        evt(3'h2);
        rd(OFS_FLAGS, 32'hc, RESP_OKAY);
        evt(3'h4);
        rd(OFS_FLAGS, 32'h8, RESP_OKAY);
        pid_value <= 4'hc;
        evt(3'h1);
        rd(OFS_PID, 32'hc, RESP_OKAY);
        // A token for another address must leave no trace.
        tok(7'h0, 4'h3, 5'h0, 0);
        rd(OFS_ENDP, 32'h15, RESP_OKAY);
        rd(OFS_FLAGS, 32'h8, RESP_OKAY);
        wr(OFS_EP_MARK, 32'h0, RESP_OKAY);
        tok(7'h7f, 4'h3, 5'h3, 1);
        rd(OFS_ENDP, 32'h13, RESP_OKAY);
        // Sticky token, J and CRC flags survive a new packet.
        wr(OFS_STICKY, 32'h4c, RESP_OKAY);
        ls_force_en <= 1'h1;
        ls_forced <= LS_K;
        evt(3'h2);
        evt(3'h4);
        rd(OFS_FLAGS, 32'h5c, RESP_OKAY);
        wr(OFS_FLAGS, 32'hc, RESP_OKAY);
        rd(OFS_FLAGS, 32'h50, RESP_OKAY);
        // Only the strobed byte may change: valid drops, data stays.
        s_axi_wstrb <= 4'h2;
        wr(OFS_POWER, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(OFS_POWER, 32'hff, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'hffffffff, RESP_SLVERR);
        // A second reset in mid-run returns the stored values to their reset values.
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        check(32'({utmi_txse0, utmi_txdata, utmi_txenable_n,
            utmi_fslsserial}), 32'h2);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(OFS_OTG_MASK, 32'h0, RESP_OKAY);
        rd(OFS_POWER, 32'h0, RESP_OKAY);
        conclude();
    end
endmodule : tb_top
